// ### test/amd_mem_model.sv
// Behavioural data memory that answers the decoder's pointer reads.
`timescale 1ns/1ps
module amd_mem_model (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic [2:0]  lat,
   input  wire logic        rd_req,
   input  wire logic [15:0] rd_addr,
   output logic             rd_ack,
   output logic [7:0]       rd_data
);
   logic [2:0] wait_cnt;

   // Content is address plus 30h; between answers the data lines toggle
   // so that a decoder sampling outside rd_ack sees a byte that flips every cycle.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_ack   <= 1'b0;
         rd_data  <= 8'hA5;
         wait_cnt <= 3'h0;
      end else begin
         rd_ack <= 1'b0;
         if (rd_req && !rd_ack && wait_cnt >= lat) begin
            rd_ack   <= 1'b1;
            rd_data  <= rd_addr[7:0] + 8'h30;
            wait_cnt <= 3'h0;
         end else begin
            rd_data  <= ~rd_data;
            wait_cnt <= rd_req ? wait_cnt + 3'h1 : 3'h0;
         end
      end
   end
endmodule

// ### test/testbench.sv
// Self-checking bench of the address mode decoder.
`timescale 1ns/1ps
module testbench
   import amd_pkg::*;
;
   logic        clk, rstn, fetch_valid, fetch_ready, wake_in;
   logic [7:0]  fetch_byte, x_reg, y_reg, rd_data;
   logic [15:0] fetch_pc, rd_addr;
   logic        rd_req, rd_ack, dec_done, halt_req, wait_req;
   logic [1:0]  mask_level;
   logic [2:0]  lat;
   amd_opinfo_s op_info;
   amd_result_s dec_res;
   int          err_count, checks_done;

   amd_decoder dut (.clk(clk), .rstn(rstn), .fetch_valid(fetch_valid),
      .fetch_byte(fetch_byte), .fetch_pc(fetch_pc), .op_info(op_info),
      .fetch_ready(fetch_ready), .x_reg(x_reg), .y_reg(y_reg),
      .rd_req(rd_req), .rd_addr(rd_addr), .rd_ack(rd_ack),
      .rd_data(rd_data), .wake_in(wake_in), .dec_done(dec_done),
      .dec_res(dec_res), .mask_level(mask_level),
      .halt_req(halt_req), .wait_req(wait_req));

   amd_mem_model mem (.clk(clk), .rstn(rstn), .lat(lat), .rd_req(rd_req),
      .rd_addr(rd_addr), .rd_ack(rd_ack), .rd_data(rd_data));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic tally_and_finish;
      $display("Mismatches %0d, comparisons %0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Offers one byte and holds it until the edge that takes it.
   task automatic put(input logic [7:0] b);
      logic r;
      fetch_valid = 1'b1;
      fetch_byte  = b;
      for (int i = 0; i < 40; i++) begin
         @(negedge clk);
         r = fetch_ready;
         @(posedge clk);
         #1;
         if (r === 1'b1) break;
      end
   endtask

   // A zero prebyte argument means no prebyte is sent.
   task automatic issue(input logic [7:0] pf, input amd_mode_e m,
                        input amd_kind_e k, input logic [15:0] w,
                        input int nb);
      int i;
      fetch_pc = 16'h1000;
      op_info  = {m, k};
      if (pf != 8'h00) put(pf);
      put(8'hC6);
      if (nb == 2) put(w[15:8]);
      if (nb > 0) put(w[7:0]);
      fetch_valid = 1'b0;
      for (i = 0; i < 40; i++) begin
         @(posedge clk);
         #1;
         if (dec_done === 1'b1) break;
      end
      if (i == 40) chk(16'hDEAD, 16'h0000);
   endtask

   task automatic s_basic;
      issue(8'h00, M_INH, K_OTHER, 16'h0000, 0);
      chk(dec_res.length, 3'h1);
      issue(8'h00, M_IMM, K_OTHER, 16'h0055, 1);
      chk(dec_res.operand, 8'h55);
      chk(dec_res.length, 3'h2);
      issue(8'h00, M_DIR_S, K_OTHER, 16'h0080, 1);
      chk(dec_res.ea, 16'h0080);
      issue(8'h00, M_DIR_L, K_OTHER, 16'h1000, 2);
      chk(dec_res.ea, 16'h1000);
      chk(dec_res.length, 3'h3);
   endtask

   task automatic s_index;
      x_reg = 8'hFF;
      y_reg = 8'h11;
      issue(8'h00, M_IDX0, K_OTHER, 16'h0000, 0);
      chk(dec_res.ea, 16'h00FF);
      chk(dec_res.length, 3'h1);
      issue(8'h00, M_IDX_S, K_OTHER, 16'h00FF, 1);
      chk(dec_res.ea, 16'h01FE);
      issue(8'h00, M_IDX_L, K_OTHER, 16'h1234, 2);
      chk(dec_res.ea, 16'h1333);
      issue(AMD_PRE_Y, M_IDX_S, K_OTHER, 16'h0010, 1);
      chk(dec_res.ea, 16'h0021);
      chk(dec_res.use_y, 1'b1);
      chk(dec_res.length, 3'h3);
   endtask

   task automatic s_indirect;
      lat = 3'h0;
      issue(AMD_PRE_IND, M_DIR_S, K_OTHER, 16'h0010, 1);
      chk(dec_res.ea, 16'h0040);
      chk(dec_res.mode, M_IND_S);
      chk(dec_res.length, 3'h3);
      lat = 3'h2;
      issue(AMD_PRE_IND, M_DIR_L, K_OTHER, 16'h0010, 1);
      chk(dec_res.ea, 16'h4041);
      issue(AMD_PRE_IND, M_IDX_S, K_OTHER, 16'h0020, 1);
      chk(dec_res.ea, 16'h014F);
      issue(AMD_PRE_IND, M_IDX_L, K_OTHER, 16'h0020, 1);
      chk(dec_res.ea, 16'h5150);
      issue(AMD_PRE_YIND, M_IDX_S, K_OTHER, 16'h0020, 1);
      chk(dec_res.ea, 16'h0061);
      chk(dec_res.use_y, 1'b1);
      chk(dec_res.mode, M_IIDX_S);
      // A prebyte that does not fit the base mode is flagged, not mapped.
      issue(AMD_PRE_YIND, M_DIR_S, K_OTHER, 16'h0010, 1);
      chk(dec_res.illegal, 1'b1);
      chk(dec_res.mode, M_DIR_S);
   endtask

   task automatic s_rel;
      issue(8'h00, M_REL_D, K_OTHER, 16'h0080, 1);
      chk(dec_res.target, 16'h0F82);
      issue(AMD_PRE_IND, M_REL_D, K_OTHER, 16'h0010, 1);
      chk(dec_res.target, 16'h1043);
      issue(AMD_PRE_IND, M_BITREL_D, K_SHORT_ONLY, 16'h10FE, 2);
      chk(dec_res.ea, 16'h0040);
      chk(dec_res.target, 16'h1002);
      chk(dec_res.length, 3'h4);
      chk(dec_res.illegal, 1'b0);
   endtask

   task automatic s_short;
      issue(8'h00, M_DIR_L, K_SHORT_ONLY, 16'h1000, 2);
      chk(dec_res.illegal, 1'b1);
      issue(8'h00, M_DIR_S, K_SHORT_ONLY, 16'h0010, 1);
      chk(dec_res.illegal, 1'b0);
      issue(8'h00, M_BIT_D, K_SHORT_ONLY, 16'h0033, 1);
      chk(dec_res.ea, 16'h0033);
      chk(dec_res.length, 3'h2);
   endtask

   task automatic s_mask;
      chk(mask_level, AMD_MASK_RST);
      issue(8'h00, M_INH, K_MASK_CLR, 16'h0000, 0);
      @(posedge clk);
      #1;
      chk(mask_level, AMD_MASK_OPEN);
      issue(8'h00, M_INH, K_MASK_SET, 16'h0000, 0);
      @(posedge clk);
      #1;
      chk(mask_level, AMD_MASK_BLOCK);
   endtask

   // Both sleep kinds must hold off fetch until the wake line rises.
   task automatic s_power(input amd_kind_e k);
      issue(8'h00, M_INH, k, 16'h0000, 0);
      @(posedge clk);
      #1;
      chk({halt_req, wait_req}, (k == K_HALT) ? 2'h2 : 2'h1);
      chk(fetch_ready, 1'b0);
      wake_in = 1'b1;
      @(posedge clk);
      #1;
      wake_in = 1'b0;
      @(posedge clk);
      #1;
      chk({halt_req, wait_req}, 2'h0);
   endtask

   initial begin
      #20000;
      err_count++;
      tally_and_finish();
   end

   initial begin
      err_count   = 0;
      checks_done = 0;
      rstn        = 1'b0;
      fetch_valid = 1'b0;
      fetch_byte  = 8'h00;
      fetch_pc    = 16'h0000;
      op_info     = {M_INH, K_OTHER};
      x_reg       = 8'h00;
      y_reg       = 8'h00;
      wake_in     = 1'b0;
      lat         = 3'h0;
      repeat (3) @(posedge clk);
      #1;
      rstn = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      s_mask();
      s_basic();
      s_index();
      s_indirect();
      s_rel();
      s_short();
      s_power(K_HALT);
      s_power(K_WAIT);
      tally_and_finish();
   end
endmodule

// ### verilog/amd_decoder.sv
// Instruction length and operand address decoder of the 8-bit core.
// Operation
// - No-operand instructions are one byte plus any prebyte
// - Immediate: opcode plus one operand byte
// - Short direct: one byte, page zero
// - Long direct: two-byte word address
// - Indexed address is unsigned index plus offset
// - No-offset indexed: no byte, 00 to FF
// - Short indexed: byte offset, up to 1FE
// - Long indexed: word offset, full space
// - Indirect reads operand address at pointer
// - Indirect indexed adds index to the address read at pointer
// - Relative adds signed 8-bit offset to PC plus length
// - Offset follows opcode or comes from memory
// - Short-only instructions refuse long forms
// - Mask set gives level 3, clear 0
// - Halt and wait enter low power
// - Prebyte 90 swaps X for Y
// - Prebyte 92 makes direct forms indirect
// - Prebyte 91 makes indirect X use Y
`timescale 1ns/1ps
module amd_decoder
   import amd_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        fetch_valid,
   input  wire logic [7:0]  fetch_byte,
   input  wire logic [15:0] fetch_pc,
   input  wire amd_opinfo_s op_info,
   output logic             fetch_ready,
   input  wire logic [7:0]  x_reg,
   input  wire logic [7:0]  y_reg,
   output logic             rd_req,
   output logic [15:0]      rd_addr,
   input  wire logic        rd_ack,
   input  wire logic [7:0]  rd_data,
   input  wire logic        wake_in,
   output logic             dec_done,
   output amd_result_s      dec_res,
   output logic [1:0]       mask_level,
   output logic             halt_req,
   output logic             wait_req
);

   typedef struct packed {
      amd_state_e  st;
      amd_pfx_e    pfx;
      amd_opinfo_s info;
      logic [7:0]  b0;
      logic [7:0]  b1;
      logic [1:0]  cnt;
      logic [7:0]  p0;
      logic [7:0]  p1;
      logic [1:0]  pcnt;
      logic [15:0] pc;
      logic        done;
      amd_result_s res;
      logic [1:0]  mask;
      logic        halt;
      logic        wait_lp;
   } amd_dec_s;

   amd_dec_s   s_reg;
   amd_dec_s   s_next;
   logic [1:0] rst_sync_reg;
   logic       rst_n;
   amd_mode_e  mode;
   logic       use_y;
   logic       bad_pfx;
   logic [1:0] need_opnd;
   logic [1:0] need_ptr;
   logic [7:0] idx;
   logic [2:0] len;
   logic [15:0] ea;
   logic [7:0] off;
   logic       asleep;

   // Reset is released through two flops so every state flop leaves
   // reset on the same edge.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   amd_mode_map u_map (
      .base_mode (s_reg.info.mode),
      .pfx       (s_reg.pfx),
      .mode      (mode),
      .use_y     (use_y),
      .bad_pfx   (bad_pfx)
   );

   assign need_opnd = amd_opnd_count(mode);
   assign need_ptr  = amd_ptr_count(mode);
   assign idx       = use_y ? y_reg : x_reg;
   assign asleep    = s_reg.halt || s_reg.wait_lp;

   assign len = 3'h1 + {2'h0, (s_reg.pfx != PF_NONE)} + {1'b0, need_opnd};

   assign fetch_ready = !asleep &&
      ((s_reg.st == S_OP) ||
       ((s_reg.st == S_OPND) && (s_reg.cnt != need_opnd)));

   // Pointer sits in page zero; a word pointer is read high byte first.
   assign rd_req  = (s_reg.st == S_PTR) && (s_reg.pcnt != need_ptr);
   assign rd_addr = {AMD_PAGE_ZERO, s_reg.b0 + {6'h00, s_reg.pcnt}};

   assign dec_done   = s_reg.done;
   assign dec_res    = s_reg.res;
   assign mask_level = s_reg.mask;
   assign halt_req   = s_reg.halt;
   assign wait_req   = s_reg.wait_lp;

   always_comb begin
      ea  = 16'h0000;
      off = 8'h00;
      case (mode)
         M_DIR_S, M_BIT_D, M_BITREL_D: ea = {AMD_PAGE_ZERO, s_reg.b0};
         M_DIR_L: ea = {s_reg.b0, s_reg.b1};
         M_IDX0: ea = {AMD_PAGE_ZERO, idx};
         M_IDX_S: ea = {AMD_PAGE_ZERO, s_reg.b0} + {AMD_PAGE_ZERO, idx};
         M_IDX_L: ea = {s_reg.b0, s_reg.b1} + {AMD_PAGE_ZERO, idx};
         M_IND_S, M_BIT_I, M_BITREL_I: ea = {AMD_PAGE_ZERO, s_reg.p0};
         M_IND_L: ea = {s_reg.p0, s_reg.p1};
         M_IIDX_S: ea = {AMD_PAGE_ZERO, s_reg.p0} + {AMD_PAGE_ZERO, idx};
         M_IIDX_L: ea = {s_reg.p0, s_reg.p1} + {AMD_PAGE_ZERO, idx};
         default: ea = 16'h0000;
      endcase
      case (mode)
         M_REL_D:                off = s_reg.b0;
         M_REL_I:                off = s_reg.p0;
         M_BITREL_D, M_BITREL_I: off = s_reg.b1;
         default:                off = 8'h00;
      endcase
   end

   always_comb begin
      s_next      = s_reg;
      s_next.done = 1'b0;
      if (wake_in) begin
         s_next.halt    = 1'b0;
         s_next.wait_lp = 1'b0;
      end
      unique case (s_reg.st)
         S_OP: begin
            if (fetch_valid && fetch_ready) begin
               if (s_reg.pfx == PF_NONE) begin
                  s_next.pc = fetch_pc;
               end
               if (fetch_byte == AMD_PRE_Y) begin
                  s_next.pfx = PF_Y;
               end else if (fetch_byte == AMD_PRE_IND) begin
                  s_next.pfx = PF_IND;
               end else if (fetch_byte == AMD_PRE_YIND) begin
                  s_next.pfx = PF_YIND;
               end else begin
                  s_next.info = op_info;
                  s_next.cnt  = 2'h0;
                  s_next.pcnt = 2'h0;
                  s_next.st   = S_OPND;
               end
            end
         end
         S_OPND: begin
            if (s_reg.cnt == need_opnd) begin
               s_next.st = (need_ptr != 2'h0) ? S_PTR : S_EXEC;
            end else if (fetch_valid && fetch_ready) begin
               if (s_reg.cnt == 2'h0) begin
                  s_next.b0 = fetch_byte;
               end else begin
                  s_next.b1 = fetch_byte;
               end
               s_next.cnt = s_reg.cnt + 2'h1;
            end
         end
         S_PTR: begin
            if (s_reg.pcnt == need_ptr) begin
               s_next.st = S_EXEC;
            end else if (rd_ack) begin
               if (s_reg.pcnt == 2'h0) begin
                  s_next.p0 = rd_data;
               end else begin
                  s_next.p1 = rd_data;
               end
               s_next.pcnt = s_reg.pcnt + 2'h1;
            end
         end
         S_EXEC: begin
            s_next.done        = 1'b1;
            s_next.res.length  = len;
            s_next.res.ea      = ea;
            s_next.res.operand = (mode == M_IMM) ? s_reg.b0 : off;
            s_next.res.target  = s_reg.pc + {13'h0000, len} +
                                 {{8{off[7]}}, off};
            s_next.res.use_y   = use_y;
            s_next.res.mode    = mode;
            s_next.res.illegal = bad_pfx ||
               ((s_reg.info.kind == K_SHORT_ONLY) && amd_is_long(mode));
            if (s_reg.info.kind == K_MASK_SET) begin
               s_next.mask = AMD_MASK_BLOCK;
            end else if (s_reg.info.kind == K_MASK_CLR) begin
               s_next.mask = AMD_MASK_OPEN;
            end
            // Entry beats a same-cycle wake so the request is not lost.
            if (s_reg.info.kind == K_HALT) begin
               s_next.halt = 1'b1;
            end
            if (s_reg.info.kind == K_WAIT) begin
               s_next.wait_lp = 1'b1;
            end
            s_next.pfx = PF_NONE;
            s_next.st  = S_OP;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg      <= '0;
         s_reg.mask <= AMD_MASK_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   a_inh_length: assert property (@(posedge clk) disable iff (!rst_n)
      dec_done && (dec_res.mode == M_INH) |->
      (dec_res.length == 3'h1) || (dec_res.length == 3'h2))
      else $error("inherent instruction length wrong");

   a_imm_operand: assert property (@(posedge clk) disable iff (!rst_n)
      (s_reg.st == S_EXEC) && (mode == M_IMM) |=>
      dec_done && (dec_res.operand == $past(s_reg.b0)) &&
      (dec_res.length >= 3'h2))
      else $error("immediate operand or length wrong");

   a_dir_page: assert property (@(posedge clk) disable iff (!rst_n)
      dec_done && (dec_res.mode == M_DIR_S) |-> dec_res.ea[15:8] == 8'h00)
      else $error("short direct left page zero");

   a_idx0_page: assert property (@(posedge clk) disable iff (!rst_n)
      dec_done && (dec_res.mode == M_IDX0) |-> dec_res.ea[15:8] == 8'h00)
      else $error("no-offset indexed left page zero");

   a_idx_short_max: assert property (@(posedge clk) disable iff (!rst_n)
      dec_done && (dec_res.mode inside {M_IDX_S, M_IIDX_S}) |->
      dec_res.ea <= AMD_IDX_S_MAX)
      else $error("short indexed beyond 1FE");

   a_long_refused: assert property (@(posedge clk) disable iff (!rst_n)
      (s_reg.st == S_EXEC) && (s_reg.info.kind == K_SHORT_ONLY) &&
      amd_is_long(mode) |=> dec_done && dec_res.illegal)
      else $error("long form accepted for short-only instruction");

   a_mask_set: assert property (@(posedge clk) disable iff (!rst_n)
      (s_reg.st == S_EXEC) && (s_reg.info.kind == K_MASK_SET) |=>
      (mask_level == 2'h3) && dec_done)
      else $error("mask set did not reach level 3");

   a_mask_clr: assert property (@(posedge clk) disable iff (!rst_n)
      (s_reg.st == S_EXEC) && (s_reg.info.kind == K_MASK_CLR) |=>
      (mask_level == 2'h0))
      else $error("mask clear did not reach level 0");

   a_sleep_stall: assert property (@(posedge clk) disable iff (!rst_n)
      (s_reg.st == S_EXEC) && (s_reg.info.kind == K_HALT) |=>
      halt_req && !fetch_ready)
      else $error("halt did not stop fetching");

   a_ptr_read: assert property (@(posedge clk) disable iff (!rst_n)
      rd_req |-> (s_reg.st == S_PTR) && (rd_addr[15:8] == 8'h00))
      else $error("pointer read outside page zero");

endmodule

// ### verilog/amd_mode_map.sv
// Prebyte translation of an opcode's base addressing mode.
`timescale 1ns/1ps
module amd_mode_map
   import amd_pkg::*;
(
   input  wire amd_mode_e base_mode,
   input  wire amd_pfx_e  pfx,
   output amd_mode_e      mode,
   output logic           use_y,
   output logic           bad_pfx
);

   always_comb begin
      mode    = base_mode;
      use_y   = 1'b0;
      bad_pfx = 1'b0;
      unique case (pfx)
         PF_NONE: begin
         end
         PF_Y: begin
            use_y   = 1'b1;
            bad_pfx = !(base_mode inside {M_INH, M_IMM, M_DIR_S, M_DIR_L,
                                          M_IDX0, M_IDX_S, M_IDX_L});
         end
         PF_IND: begin
            case (base_mode)
               M_DIR_S:    mode = M_IND_S;
               M_DIR_L:    mode = M_IND_L;
               M_IDX_S:    mode = M_IIDX_S;
               M_IDX_L:    mode = M_IIDX_L;
               M_REL_D:    mode = M_REL_I;
               M_BIT_D:    mode = M_BIT_I;
               M_BITREL_D: mode = M_BITREL_I;
               default:    bad_pfx = 1'b1;
            endcase
         end
         PF_YIND: begin
            use_y = 1'b1;
            case (base_mode)
               M_IDX_S: mode = M_IIDX_S;
               M_IDX_L: mode = M_IIDX_L;
               default: bad_pfx = 1'b1;
            endcase
         end
      endcase
   end

endmodule

// ### verilog/amd_pkg.sv
// Shared types and constants for the address mode decoder.
package amd_pkg;

   localparam logic [7:0] AMD_PRE_Y      = 8'h90;
   localparam logic [7:0] AMD_PRE_YIND   = 8'h91;
   localparam logic [7:0] AMD_PRE_IND    = 8'h92;
   localparam logic [1:0] AMD_MASK_BLOCK = 2'h3;
   localparam logic [1:0] AMD_MASK_OPEN  = 2'h0;
   localparam logic [1:0] AMD_MASK_RST   = 2'h3;
   localparam logic [7:0] AMD_PAGE_ZERO  = 8'h00;
   localparam logic [15:0] AMD_IDX_S_MAX = 16'h01FE;

   typedef enum logic [4:0] {
      M_INH      = 5'h00,
      M_IMM      = 5'h01,
      M_DIR_S    = 5'h02,
      M_DIR_L    = 5'h03,
      M_IDX0     = 5'h04,
      M_IDX_S    = 5'h05,
      M_IDX_L    = 5'h06,
      M_IND_S    = 5'h07,
      M_IND_L    = 5'h08,
      M_IIDX_S   = 5'h09,
      M_IIDX_L   = 5'h0A,
      M_REL_D    = 5'h0B,
      M_REL_I    = 5'h0C,
      M_BIT_D    = 5'h0D,
      M_BIT_I    = 5'h0E,
      M_BITREL_D = 5'h0F,
      M_BITREL_I = 5'h10
   } amd_mode_e;

   typedef enum logic [2:0] {
      K_OTHER      = 3'h0,
      K_SHORT_ONLY = 3'h1,
      K_MASK_SET   = 3'h2,
      K_MASK_CLR   = 3'h3,
      K_HALT       = 3'h4,
      K_WAIT       = 3'h5
   } amd_kind_e;

   typedef enum logic [1:0] {
      PF_NONE = 2'h0,
      PF_Y    = 2'h1,
      PF_IND  = 2'h2,
      PF_YIND = 2'h3
   } amd_pfx_e;

   typedef enum logic [1:0] {
      S_OP   = 2'h0,
      S_OPND = 2'h1,
      S_PTR  = 2'h2,
      S_EXEC = 2'h3
   } amd_state_e;

   typedef struct packed {
      amd_mode_e mode;
      amd_kind_e kind;
   } amd_opinfo_s;

   typedef struct packed {
      logic [2:0]  length;
      logic [15:0] ea;
      logic [7:0]  operand;
      logic [15:0] target;
      logic        use_y;
      logic        illegal;
      amd_mode_e   mode;
   } amd_result_s;

   function automatic logic [1:0] amd_opnd_count(input amd_mode_e m);
      case (m)
         M_INH, M_IDX0:               amd_opnd_count = 2'h0;
         M_DIR_L, M_IDX_L,
         M_BITREL_D, M_BITREL_I:      amd_opnd_count = 2'h2;
         default:                     amd_opnd_count = 2'h1;
      endcase
   endfunction

   function automatic logic [1:0] amd_ptr_count(input amd_mode_e m);
      case (m)
         M_IND_L, M_IIDX_L:                    amd_ptr_count = 2'h2;
         M_IND_S, M_IIDX_S, M_REL_I,
         M_BIT_I, M_BITREL_I:                  amd_ptr_count = 2'h1;
         default:                              amd_ptr_count = 2'h0;
      endcase
   endfunction

   function automatic logic amd_is_long(input amd_mode_e m);
      amd_is_long = (m == M_DIR_L) || (m == M_IDX_L) ||
                    (m == M_IND_L) || (m == M_IIDX_L);
   endfunction

endpackage
